/* File: hw/port_ctrl_pkg.sv */
package port_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          NUM_PORTS   = 4;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam int          VID_W       = 12;
  localparam logic [7:0]  PORT1_OFFS  = 8'h10;
  localparam logic [7:0]  PORT2_OFFS  = 8'h20;
  localparam logic [7:0]  PORT3_OFFS  = 8'h30;
  localparam logic [7:0]  RSVD_OFFS   = 8'h40;
  localparam logic [7:0]  PORT4_OFFS  = 8'h50;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  RDATA_NONE  = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STORM_BIT     = 7;
  localparam int DSCP_EN_BIT   = 6;
  localparam int DOT1P_EN_BIT  = 5;
  localparam int PRIO_HI_BIT   = 4;
  localparam int PRIO_LO_BIT   = 3;
  localparam int TAG_INS_BIT   = 2;
  localparam int TAG_REM_BIT   = 1;
  localparam int SPLIT_BIT     = 0;

  // ----------------------------------------------------------------
  // queue split codes {companion bit, split bit}
  // ----------------------------------------------------------------
  localparam logic [1:0] SPLIT_ONE   = 2'h0;
  localparam logic [1:0] SPLIT_TWO   = 2'h1;
  localparam logic [1:0] SPLIT_FOUR  = 2'h2;
  localparam logic [1:0] SPLIT_RSVD  = 2'h3;

  typedef logic [1:0] prio_t;
  typedef logic [1:0] port_idx_t;

endpackage : port_ctrl_pkg

/* File: hw/port_priority_tag_control.sv */
// Contract
// - every port has one control register of the same layout at its own address, and 0x40 is reserved.
// - bit 7 set turns on broadcast storm protection for ingress packets on that port.
// - bit 6 set classifies ingress packets by their DiffServ code point.
// - bit 5 set classifies ingress packets by their 802.1p user priority.
// - with no classifier enabled or none hitting, the packet goes to the port priority in bits 4-3.
// - DiffServ and 802.1p results are ORed together and override the port priority.
// - tag insertion on egress adds a tag to untagged packets and never double-tags.
// - an inserted tag carries the default VLAN id of the ingress port.
// - tag removal on egress strips the tag from packets that arrived tagged.
// - with tag removal on and tag insertion off, untagged packets leave unmodified.
// - companion bit and bit 0 form a code: 10 four queues, 01 two, 00 one, 11 reserved.
// - in single-queue mode all packets use one queue regardless of priority.
`timescale 1ns/1ps

module port_priority_tag_control
  import port_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                                      clk_i,
  input  wire logic                                      srst_i,
  // register port
  input  wire logic [port_ctrl_pkg::ADDR_W-1:0]          reg_addr_i,
  input  wire logic [port_ctrl_pkg::DATA_W-1:0]          reg_wdata_i,
  input  wire logic                                      reg_wr_i,
  input  wire logic                                      reg_rd_i,
  output logic      [port_ctrl_pkg::DATA_W-1:0]          reg_rdata_o,
  // per-port context
  input  wire logic [port_ctrl_pkg::NUM_PORTS-1:0][port_ctrl_pkg::VID_W-1:0] port_default_vlan_id_i,
  input  wire logic [port_ctrl_pkg::NUM_PORTS-1:0]       split_companion_i,
  output logic      [port_ctrl_pkg::NUM_PORTS-1:0]       storm_protect_o,
  // ingress classification
  input  wire logic                                      cls_req_i,
  input  wire port_ctrl_pkg::port_idx_t                  cls_port_i,
  input  wire logic                                      dscp_hit_i,
  input  wire port_ctrl_pkg::prio_t                      dscp_prio_i,
  input  wire logic                                      dot1p_hit_i,
  input  wire port_ctrl_pkg::prio_t                      dot1p_prio_i,
  output logic                                           cls_valid_o,
  output port_ctrl_pkg::prio_t                           cls_prio_o,
  // egress tag and queue handling
  input  wire logic                                      eg_req_i,
  input  wire port_ctrl_pkg::port_idx_t                  eg_port_i,
  input  wire port_ctrl_pkg::port_idx_t                  eg_src_port_i,
  input  wire logic                                      eg_rx_tagged_i,
  input  wire port_ctrl_pkg::prio_t                      eg_prio_i,
  output logic                                           eg_valid_o,
  output logic                                           eg_add_tag_o,
  output logic                                           eg_strip_tag_o,
  output logic      [port_ctrl_pkg::VID_W-1:0]           eg_tag_vid_o,
  output port_ctrl_pkg::prio_t                           eg_queue_o
);
  import port_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]    ctrl [NUM_PORTS];
  logic [NUM_PORTS-1:0] sel;

  // the reserved slot matches none of these, so it reads zero
  assign sel[0] = (reg_addr_i == PORT1_OFFS);
  assign sel[1] = (reg_addr_i == PORT2_OFFS);
  assign sel[2] = (reg_addr_i == PORT3_OFFS);
  assign sel[3] = (reg_addr_i == PORT4_OFFS);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          ctrl[g] <= CTRL_RESET;
        end else if (reg_wr_i && sel[g]) begin
          ctrl[g] <= reg_wdata_i;
        end
      end
      assign storm_protect_o[g] = ctrl[g][STORM_BIT];
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = RDATA_NONE;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (sel[i]) begin
        next_rdata = ctrl[i];
      end
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= RDATA_NONE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= RDATA_NONE;
    end
  end

  // ----------------------------------------------------------------
  // ingress classification
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] cls_ctrl;
  logic              dscp_use;
  logic              dot1p_use;
  prio_t             next_cls_prio;

  assign cls_ctrl  = ctrl[cls_port_i];
  assign dscp_use  = cls_ctrl[DSCP_EN_BIT] && dscp_hit_i;
  assign dot1p_use = cls_ctrl[DOT1P_EN_BIT] && dot1p_hit_i;

  always_comb begin
    if (dscp_use || dot1p_use) begin
      // a classifier that missed contributes zero to the OR
      next_cls_prio = (dscp_use ? dscp_prio_i : 2'h0)
                    | (dot1p_use ? dot1p_prio_i : 2'h0);
    end else begin
      next_cls_prio = cls_ctrl[PRIO_HI_BIT:PRIO_LO_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cls_valid_o <= 1'b0;
      cls_prio_o  <= 2'h0;
    end else begin
      cls_valid_o <= cls_req_i;
      if (cls_req_i) begin
        cls_prio_o <= next_cls_prio;
      end
    end
  end

  // ----------------------------------------------------------------
  // egress tag handling and queue selection
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] eg_ctrl;
  logic [1:0]        split_code;
  logic              next_add;
  logic              next_strip;
  prio_t             next_queue;

  assign eg_ctrl    = ctrl[eg_port_i];
  assign split_code = {split_companion_i[eg_port_i], eg_ctrl[SPLIT_BIT]};
  assign next_add   = eg_ctrl[TAG_INS_BIT] && !eg_rx_tagged_i;
  // untagged arrivals are never touched by removal
  assign next_strip = eg_ctrl[TAG_REM_BIT] && eg_rx_tagged_i;

  always_comb begin
    case (split_code)
      SPLIT_FOUR: next_queue = eg_prio_i;
      SPLIT_TWO:  next_queue = {1'b0, eg_prio_i[1]};
      SPLIT_ONE:  next_queue = 2'h0;
      // reserved code falls back to one queue, the safe choice
      default:    next_queue = 2'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eg_valid_o     <= 1'b0;
      eg_add_tag_o   <= 1'b0;
      eg_strip_tag_o <= 1'b0;
      eg_tag_vid_o   <= '0;
      eg_queue_o     <= 2'h0;
    end else begin
      eg_valid_o <= eg_req_i;
      if (eg_req_i) begin
        eg_add_tag_o   <= next_add;
        eg_strip_tag_o <= next_strip;
        eg_tag_vid_o   <= port_default_vlan_id_i[eg_src_port_i];
        eg_queue_o     <= next_queue;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic [NUM_PORTS-1:0][VID_W-1:0] vid_q;
  port_idx_t                       src_q;

  always_ff @(posedge clk_i) begin
    vid_q      <= port_default_vlan_id_i;
    src_q      <= eg_src_port_i;
  end

  reg_readback_a: assert property (
    reg_wr_i && sel[0] ##1 reg_rd_i && (reg_addr_i == PORT1_OFFS)
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("port register does not read back the written value");

  rsvd_slot_zero_a: assert property (
    reg_rd_i && (reg_addr_i == RSVD_OFFS) |=> reg_rdata_o == RDATA_NONE)
    else $error("reserved slot does not read zero");

  storm_enable_a: assert property (
    reg_wr_i && sel[3] |=> storm_protect_o[3] == $past(reg_wdata_i[STORM_BIT]))
    else $error("storm protection does not follow its control bit");

  dscp_only_a: assert property (
    cls_req_i && cls_ctrl[DSCP_EN_BIT] && dscp_hit_i && !dot1p_hit_i
      |=> cls_valid_o && cls_prio_o == $past(dscp_prio_i))
    else $error("dscp priority not applied");

  dot1p_only_a: assert property (
    cls_req_i && cls_ctrl[DOT1P_EN_BIT] && dot1p_hit_i && !dscp_hit_i
      |=> cls_prio_o == $past(dot1p_prio_i))
    else $error("802.1p priority not applied");

  port_prio_fallback_a: assert property (
    cls_req_i && !cls_ctrl[DSCP_EN_BIT] && !cls_ctrl[DOT1P_EN_BIT]
      |=> cls_prio_o == $past(cls_ctrl[PRIO_HI_BIT:PRIO_LO_BIT]))
    else $error("port priority not used when classifiers are off");

  or_combine_a: assert property (
    cls_req_i && dscp_use && dot1p_use
      |=> cls_prio_o == ($past(dscp_prio_i) | $past(dot1p_prio_i)))
    else $error("classifier results not ORed");

  tag_insert_a: assert property (
    eg_req_i |=> eg_add_tag_o == ($past(eg_ctrl[TAG_INS_BIT]) && !$past(eg_rx_tagged_i)))
    else $error("tag insertion decision wrong");

  ingress_vid_a: assert property (
    eg_req_i |=> eg_tag_vid_o == vid_q[src_q])
    else $error("inserted tag does not carry the ingress port vlan id");

  tag_strip_a: assert property (
    eg_req_i && eg_ctrl[TAG_REM_BIT] && eg_rx_tagged_i |=> eg_strip_tag_o)
    else $error("tagged packet not stripped");

  untagged_kept_a: assert property (
    eg_req_i && !eg_rx_tagged_i |=> !eg_strip_tag_o)
    else $error("untagged packet modified by removal");

  four_queue_a: assert property (
    eg_req_i && split_code == SPLIT_FOUR |=> eg_queue_o == $past(eg_prio_i))
    else $error("four-queue split does not keep priority");

  two_queue_a: assert property (
    eg_req_i && split_code == SPLIT_TWO |=> eg_queue_o == {1'b0, $past(eg_prio_i[1])})
    else $error("two-queue split wrong");

  single_queue_a: assert property (
    eg_req_i && split_code == SPLIT_ONE |=> eg_queue_o == 2'h0)
    else $error("single queue mode differentiates priority");

  rdata_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == RDATA_NONE)
    else $error("read data not zero outside the read cycle");

  unmapped_ignore_a: assert property (
    reg_wr_i && (sel == '0)
      |=> ctrl[0] == $past(ctrl[0]) && ctrl[1] == $past(ctrl[1])
       && ctrl[2] == $past(ctrl[2]) && ctrl[3] == $past(ctrl[3]))
    else $error("write to an unmapped address changed a port register");

  storm_clear_a: assert property (
    reg_wr_i && sel[0] && !reg_wdata_i[STORM_BIT] |=> !storm_protect_o[0])
    else $error("storm protection stays on after its bit is cleared");

  dscp_masked_a: assert property (
    cls_req_i && !cls_ctrl[DSCP_EN_BIT] && cls_ctrl[DOT1P_EN_BIT] && dot1p_hit_i
      |=> cls_prio_o == $past(dot1p_prio_i))
    else $error("dscp result used while its classification is off");

  dot1p_masked_a: assert property (
    cls_req_i && !cls_ctrl[DOT1P_EN_BIT] && cls_ctrl[DSCP_EN_BIT] && dscp_hit_i
      |=> cls_prio_o == $past(dscp_prio_i))
    else $error("802.1p result used while its classification is off");

  // one-cycle answer, then hold until the next request
  cls_valid_a: assert property (
    cls_req_i |=> cls_valid_o)
    else $error("classification answer missing");

  cls_idle_a: assert property (
    !cls_req_i |=> !cls_valid_o)
    else $error("classification answer without request");

  cls_hold_a: assert property (
    !cls_req_i |=> $stable(cls_prio_o))
    else $error("priority changed without request");

  no_hit_fallback_a: assert property (
    cls_req_i && !dscp_hit_i && !dot1p_hit_i
      |=> cls_prio_o == $past(cls_ctrl[PRIO_HI_BIT:PRIO_LO_BIT]))
    else $error("port priority not used when no classifier hits");

  single_hit_a: assert property (
    cls_req_i && dscp_use && !dot1p_use |=> cls_prio_o == $past(dscp_prio_i))
    else $error("missed classifier altered the combined priority");

  eg_valid_a: assert property (
    eg_req_i |=> eg_valid_o)
    else $error("egress answer missing");

  eg_idle_a: assert property (
    !eg_req_i |=> !eg_valid_o)
    else $error("egress answer without request");

  eg_hold_a: assert property (
    !eg_req_i |=> $stable(eg_tag_vid_o) && $stable(eg_queue_o)
      && $stable(eg_add_tag_o) && $stable(eg_strip_tag_o))
    else $error("egress outputs changed without request");

  tagged_no_insert_a: assert property (
    eg_req_i && eg_rx_tagged_i |=> !eg_add_tag_o)
    else $error("tagged packet given a second tag");

  strip_off_a: assert property (
    eg_req_i && !eg_ctrl[TAG_REM_BIT] |=> !eg_strip_tag_o)
    else $error("tag stripped with removal off");

  both_tag_bits_a: assert property (
    eg_req_i && eg_ctrl[TAG_INS_BIT] && eg_ctrl[TAG_REM_BIT] && eg_rx_tagged_i
      |=> eg_strip_tag_o && !eg_add_tag_o)
    else $error("tagged packet mishandled with both tag bits set");

  rsvd_split_a: assert property (
    eg_req_i && split_code == SPLIT_RSVD |=> eg_queue_o == 2'h0)
    else $error("reserved split code does not fall back to one queue");

  reset_outputs_a: assert property (
    disable iff (1'b0) $past(srst_i) |-> reg_rdata_o == RDATA_NONE
      && !cls_valid_o && !eg_valid_o && eg_queue_o == 2'h0)
    else $error("outputs not cleared by reset");

  reset_zero_a: assert property (
    disable iff (1'b0) $past(srst_i) |-> ctrl[0] == CTRL_RESET && ctrl[3] == CTRL_RESET
      && !storm_protect_o[1] && !storm_protect_o[2])
    else $error("control not zero after reset");

endmodule // port_priority_tag_control

/* File: testbench/tb.sv */
`timescale 1ns/1ps

module tb;
  import port_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                           clk_i;
  logic                           srst_i;
  logic [ADDR_W-1:0]              reg_addr_i;
  logic [DATA_W-1:0]              reg_wdata_i;
  logic                           reg_wr_i;
  logic                           reg_rd_i;
  logic [DATA_W-1:0]              reg_rdata_o;
  logic [NUM_PORTS-1:0][VID_W-1:0] vid;
  logic [NUM_PORTS-1:0]           comp;
  logic [NUM_PORTS-1:0]           storm_protect_o;
  logic                           cls_req_i;
  port_idx_t                      cls_port_i;
  logic                           dscp_hit_i;
  prio_t                          dscp_prio_i;
  logic                           dot1p_hit_i;
  prio_t                          dot1p_prio_i;
  logic                           cls_valid_o;
  prio_t                          cls_prio_o;
  logic                           eg_req_i;
  port_idx_t                      eg_port_i;
  port_idx_t                      eg_src_port_i;
  logic                           eg_rx_tagged_i;
  prio_t                          eg_prio_i;
  logic                           eg_valid_o;
  logic                           eg_add_tag_o;
  logic                           eg_strip_tag_o;
  logic [VID_W-1:0]               eg_tag_vid_o;
  prio_t                          eg_queue_o;
  int                             bad_count;
  int                             n_checks;

  port_priority_tag_control i_port_priority_tag_control (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .port_default_vlan_id_i(vid), .split_companion_i(comp), .storm_protect_o(storm_protect_o),
    .cls_req_i(cls_req_i), .cls_port_i(cls_port_i), .dscp_hit_i(dscp_hit_i),
    .dscp_prio_i(dscp_prio_i), .dot1p_hit_i(dot1p_hit_i), .dot1p_prio_i(dot1p_prio_i),
    .cls_valid_o(cls_valid_o), .cls_prio_o(cls_prio_o), .eg_req_i(eg_req_i),
    .eg_port_i(eg_port_i), .eg_src_port_i(eg_src_port_i), .eg_rx_tagged_i(eg_rx_tagged_i),
    .eg_prio_i(eg_prio_i), .eg_valid_o(eg_valid_o), .eg_add_tag_o(eg_add_tag_o),
    .eg_strip_tag_o(eg_strip_tag_o), .eg_tag_vid_o(eg_tag_vid_o), .eg_queue_o(eg_queue_o)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check("rdata", reg_rdata_o, exp);
  endtask

  task automatic clsc(input logic [7:0] c, input logic dh, input prio_t dp, input logic oh,
                      input prio_t op, input prio_t exp);
    wr(PORT2_OFFS, c);
    @(posedge clk_i);
    cls_req_i <= 1'b1; cls_port_i <= 2'h1;
    dscp_hit_i <= dh; dscp_prio_i <= dp; dot1p_hit_i <= oh; dot1p_prio_i <= op;
    @(posedge clk_i);
    cls_req_i <= 1'b0;
    #1 check("cls_valid", cls_valid_o, 1'b1);
    check("cls_prio", cls_prio_o, exp);
  endtask

  task automatic egc(input logic [7:0] c, input logic cb, input port_idx_t src, input logic tg,
                     input prio_t pr, input logic ea, input logic es, input prio_t eq);
    wr(PORT4_OFFS, c);
    @(posedge clk_i);
    comp[3] <= cb; eg_req_i <= 1'b1; eg_port_i <= 2'h3;
    eg_src_port_i <= src; eg_rx_tagged_i <= tg; eg_prio_i <= pr;
    @(posedge clk_i);
    eg_req_i <= 1'b0;
    #1 check("eg_valid", eg_valid_o, 1'b1);
    check("eg_add", eg_add_tag_o, ea);
    check("eg_strip", eg_strip_tag_o, es);
    check("eg_vid", eg_tag_vid_o, vid[src]);
    check("eg_queue", eg_queue_o, eq);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  initial begin
    bad_count = 0; n_checks = 0;
    srst_i = 1'b1; reg_addr_i = 8'h00; reg_wdata_i = 8'h00; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
    vid = {12'hD04, 12'hC03, 12'hB02, 12'hA01}; comp = 4'h0;
    cls_req_i = 1'b0; cls_port_i = 2'h0; dscp_hit_i = 1'b0; dscp_prio_i = 2'h0;
    dot1p_hit_i = 1'b0; dot1p_prio_i = 2'h0; eg_req_i = 1'b0; eg_port_i = 2'h0;
    eg_src_port_i = 2'h0; eg_rx_tagged_i = 1'b0; eg_prio_i = 2'h0;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 check("storm", storm_protect_o, 4'h0);
    check("valids", {cls_valid_o, eg_valid_o}, 2'h0);
    rd(PORT1_OFFS, 8'h00);
    rd(PORT2_OFFS, 8'h00);
    rd(PORT3_OFFS, 8'h00);
    rd(PORT4_OFFS, 8'h00);
    wr(PORT1_OFFS, 8'h81);
    wr(PORT2_OFFS, 8'h42);
    wr(PORT3_OFFS, 8'hA4);
    wr(PORT4_OFFS, 8'h18);
    wr(RSVD_OFFS, 8'hFF);
    #1 check("storm", storm_protect_o, 4'h5);
    rd(PORT1_OFFS, 8'h81);
    @(posedge clk_i);
    #1 check("rdata idle", reg_rdata_o, RDATA_NONE);
    rd(PORT2_OFFS, 8'h42);
    rd(PORT3_OFFS, 8'hA4);
    rd(PORT4_OFFS, 8'h18);
    rd(RSVD_OFFS, 8'h00);
    rd(8'h41, 8'h00);
    // write then read with no gap between the strobes
    @(posedge clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= PORT1_OFFS; reg_wdata_i <= 8'h81;
    @(posedge clk_i);
    reg_wr_i <= 1'b0; reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check("rdata b2b", reg_rdata_o, 8'h81);
    // port2 control: bits 6/5 enables, bits 4:3 port priority
    clsc(8'h18, 1'b1, 2'h1, 1'b1, 2'h2, 2'h3);
    clsc(8'h58, 1'b1, 2'h1, 1'b1, 2'h2, 2'h1);
    clsc(8'h58, 1'b0, 2'h1, 1'b1, 2'h2, 2'h3);
    clsc(8'h30, 1'b1, 2'h1, 1'b1, 2'h2, 2'h2);
    clsc(8'h68, 1'b1, 2'h1, 1'b1, 2'h2, 2'h3);
    clsc(8'h78, 1'b1, 2'h0, 1'b0, 2'h3, 2'h0);
    #1 check("storm", storm_protect_o, 4'h5);
    // port4 control: bit 2 insert, bit 1 remove, bit 0 split
    egc(8'h04, 1'b0, 2'h1, 1'b0, 2'h3, 1'b1, 1'b0, 2'h0);
    egc(8'h04, 1'b0, 2'h0, 1'b1, 2'h3, 1'b0, 1'b0, 2'h0);
    egc(8'h02, 1'b0, 2'h2, 1'b1, 2'h2, 1'b0, 1'b1, 2'h0);
    egc(8'h02, 1'b0, 2'h3, 1'b0, 2'h2, 1'b0, 1'b0, 2'h0);
    egc(8'h00, 1'b1, 2'h1, 1'b0, 2'h3, 1'b0, 1'b0, 2'h3);
    egc(8'h01, 1'b0, 2'h0, 1'b0, 2'h2, 1'b0, 1'b0, 2'h1);
    egc(8'h01, 1'b0, 2'h0, 1'b0, 2'h1, 1'b0, 1'b0, 2'h0);
    egc(8'h01, 1'b1, 2'h2, 1'b0, 2'h3, 1'b0, 1'b0, 2'h0);
    egc(8'h00, 1'b0, 2'h3, 1'b0, 2'h3, 1'b0, 1'b0, 2'h0);
    conclude();
  end

endmodule // tb
